/* core/awb_consts.vh */
// constants for the bus write buffer: depths, entry layouts, bus codes
// assumes inclusion by every design file of the buffer
`ifndef AWB_CONSTS_VH
`define AWB_CONSTS_VH

// ----------------------------------------------------------------------------
// buffer geometry
// ----------------------------------------------------------------------------
`define AWB_ADDR_DEPTH      4
`define AWB_ADDR_PTRW       2
`define AWB_DATA_DEPTH      8
`define AWB_DATA_PTRW       3

// address entry: {unbuffered, size[1:0], address[31:0]}
`define AWB_AENT_W          35
`define AWB_AENT_UNBUF      34
`define AWB_AENT_SIZE_HI    33
`define AWB_AENT_SIZE_LO    32
// data entry: {sequential, data[31:0]}
`define AWB_DENT_W          33
`define AWB_DENT_SEQ        32

// ----------------------------------------------------------------------------
// bus encodings
// ----------------------------------------------------------------------------
`define AWB_TRANS_IDLE      2'h0
`define AWB_TRANS_NSEQ      2'h2
`define AWB_TRANS_SEQ       2'h3
`define AWB_SIZE_WORD       3'h2
`define AWB_BURST_INCR      3'h1
`define AWB_RESP_ERROR      2'h1
`define AWB_WORD_STEP       32'h00000004
`define AWB_KB_LSB_W        10

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define AWB_RST_ADDR        32'h00000000
`define AWB_RST_DATA        32'h00000000

`endif

/* core/awb_fifo.v */
// first-in first-out store of fixed depth, one push and one pop a cycle
// assumes push only when not full and pop only when not empty
`include "awb_consts.vh"
`default_nettype none

module awb_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter PTRW  = 2
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             push,
    input  wire [WIDTH-1:0] pushData,
    input  wire             pop,
    output wire [WIDTH-1:0] headData,
    output wire [PTRW:0]    count,
    output wire             empty,
    output wire             full
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTRW-1:0]  wrPtr_q;
    reg [PTRW-1:0]  rdPtr_q;
    reg [PTRW:0]    count_q;

    assign headData = mem[rdPtr_q];
    assign count    = count_q;
    assign empty    = (count_q == {(PTRW+1){1'b0}});
    assign full     = (count_q == DEPTH[PTRW:0]);

    always @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_q] <= pushData;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= {PTRW{1'b0}};
            rdPtr_q <= {PTRW{1'b0}};
            count_q <= {(PTRW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + {{(PTRW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + {{(PTRW-1){1'b0}}, 1'b1};
            end
            count_q <= count_q + {{PTRW{1'b0}}, push} - {{PTRW{1'b0}}, pop};
        end
    end
endmodule // awb_fifo

`default_nettype wire

/* core/awb_incr.v */
// word address incrementer with 1KB boundary detection
// assumes a word-aligned base address
`include "awb_consts.vh"
`default_nettype none

module awb_incr (
    input  wire [31:0] baseAddr,
    output wire [31:0] nextAddr,
    output wire        crossesKb
);
    assign nextAddr  = baseAddr + `AWB_WORD_STEP;
    assign crossesKb = (nextAddr[`AWB_KB_LSB_W-1:0] == {`AWB_KB_LSB_W{1'b0}});
endmodule // awb_incr

`default_nettype wire

/* core/awb_write_buffer.v */
// bus write buffer: four address and eight data entries drained as bus writes
// assumes bus clock synchronous to ref_clk, marked by busClkEn
//
// How it works
// - address and data are kept in separate queues of four and eight entries.
// - an accepted buffered write frees the core at once.
// - a buffered write waits while either queue lacks a free entry.
// - buffer only when enabled, bufferable, in bus space and no memory hit.
// - address takes next address entry; each store_multiple word takes a data entry.
// - every separate store uses its own address entry.
// - any buffered data starts a bus write by itself, address then data.
// - each address entry carries a size tag that drives the bus size.
// - store_multiple words carry a sequential tag; later addresses come from incrementer.
// - reads, fetches, loads and unbuffered writes wait for a full drain.
// - drain ends only after the last write completed on the bus.
// - drain command waits until empty and final write completed.
// - enable bit allows bufferable writes in bus space with no memory hit into the buffer.
// - error answers to buffered writes are dropped, no abort.
// - clearing enable keeps all buffered entries, they still go out.
// - wait-for-interrupt also lets all pending data drain out.
// - address phase precedes data phase; next address overlaps current data.
// - ready low stretches the data phase; pipelined address is held.
// - sequential runs crossing 1KB split, idle between, each set opens nonsequential.
// - single stores show as nonsequential followed by idle.
// - a new access after store_multiple opens nonsequential after its last beat.
// - bus outputs change only on edges with the bus clock enable high.
// - a transfer completes only when ready and bus clock enable are high.
`include "awb_consts.vh"
`default_nettype none

module awb_write_buffer (
    input  wire        ref_clk,
    input  wire        rst,
    // core store path
    input  wire        wrValid,
    input  wire [31:0] wrAddr,
    input  wire [1:0]  wrSize,
    input  wire [31:0] wrData,
    input  wire        wrSeq,
    input  wire        wrBufferable,
    input  wire        wrBusSpace,
    input  wire        wrTcmHit,
    output wire        wrReady,
    output wire        wrDone,
    output wire        wrError,
    // control and drain requests
    input  wire        bufEnable,
    input  wire        accessReq,
    input  wire        drainCmd,
    input  wire        waitForInt,
    output wire        drainDone,
    // bus master
    input  wire        busClkEn,
    input  wire        HREADY,
    input  wire [1:0]  HRESP,
    output wire [31:0] HADDR,
    output wire [1:0]  HTRANS,
    output wire        HWRITE,
    output wire [2:0]  HSIZE,
    output wire [2:0]  HBURST,
    output wire [31:0] HWDATA
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    reg        wrReady_q;
    reg        wrDone_q;
    reg        wrError_q;
    reg        drainDone_q;
    reg        unbufBusy_q;
    reg [31:0] haddr_q;
    reg [1:0]  htrans_q;
    reg        hwrite_q;
    reg [2:0]  hsize_q;
    reg [2:0]  hburst_q;
    reg [31:0] hwdata_q;
    reg [31:0] apData_q;
    reg        apUnbuf_q;
    reg        dphValid_q;
    reg        dphUnbuf_q;
    reg [31:0] lastAddr_q;

    wire [`AWB_AENT_W-1:0]  aHead;
    wire [`AWB_DENT_W-1:0]  dHead;
    wire [`AWB_ADDR_PTRW:0] aCount;
    wire [`AWB_DATA_PTRW:0] dCount;
    wire                    aEmpty;
    wire                    aFull;
    wire                    dEmpty;
    wire                    dFull;
    wire [31:0]             incAddr;
    wire                    crossKb;

    // ------------------------------------------------------------------------
    // write acceptance
    // ------------------------------------------------------------------------
    wire bufOk     = bufEnable & wrBufferable & wrBusSpace & ~wrTcmHit;
    wire bufPush   = wrValid & bufOk & wrReady_q;
    wire advance   = busClkEn & HREADY;
    wire prevActive = (htrans_q != `AWB_TRANS_IDLE);
    wire busIdle   = aEmpty & dEmpty & ~prevActive & ~dphValid_q;
    // unbuffered write enters only behind a fully drained bus
    wire unbufPush = wrValid & ~bufOk & busIdle & ~unbufBusy_q & ~wrDone_q;
    wire aPush     = (bufPush & ~wrSeq) | unbufPush;
    wire dPush     = bufPush | unbufPush;

    wire [`AWB_AENT_W-1:0] aEntry = {unbufPush, wrSize, wrAddr};
    wire [`AWB_DENT_W-1:0] dEntry = {bufPush & wrSeq, wrData};

    // ------------------------------------------------------------------------
    // issue selection
    // ------------------------------------------------------------------------
    wire seqBeat  = dHead[`AWB_DENT_SEQ];
    wire canIssue = ~dEmpty & (seqBeat | ~aEmpty);
    wire candSeq  = seqBeat & prevActive & ~crossKb;
    // a new set always opens after an idle slot
    wire issue    = canIssue & (candSeq | ~prevActive);
    wire aPop     = advance & issue & ~seqBeat;
    wire dPop     = advance & issue;
    wire [31:0] candAddr = seqBeat ? incAddr : aHead[31:0];
    wire [2:0]  candSize = seqBeat ? `AWB_SIZE_WORD :
                           {1'b0, aHead[`AWB_AENT_SIZE_HI:`AWB_AENT_SIZE_LO]};

    wire [`AWB_ADDR_PTRW:0] aCountNext = aCount + {{`AWB_ADDR_PTRW{1'b0}}, aPush}
                                                - {{`AWB_ADDR_PTRW{1'b0}}, aPop};
    wire [`AWB_DATA_PTRW:0] dCountNext = dCount + {{`AWB_DATA_PTRW{1'b0}}, dPush}
                                                - {{`AWB_DATA_PTRW{1'b0}}, dPop};

    // nothing queued, nothing on the bus, nothing arriving
    wire allDone = busIdle & ~aPush & ~dPush & ~unbufBusy_q;

    // ------------------------------------------------------------------------
    // queues
    // ------------------------------------------------------------------------
    awb_fifo #(
        .WIDTH (`AWB_AENT_W),
        .DEPTH (`AWB_ADDR_DEPTH),
        .PTRW  (`AWB_ADDR_PTRW)
    ) addrQueue (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .push     (aPush),
        .pushData (aEntry),
        .pop      (aPop),
        .headData (aHead),
        .count    (aCount),
        .empty    (aEmpty),
        .full     (aFull)
    );

    awb_fifo #(
        .WIDTH (`AWB_DENT_W),
        .DEPTH (`AWB_DATA_DEPTH),
        .PTRW  (`AWB_DATA_PTRW)
    ) dataQueue (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .push     (dPush),
        .pushData (dEntry),
        .pop      (dPop),
        .headData (dHead),
        .count    (dCount),
        .empty    (dEmpty),
        .full     (dFull)
    );

    awb_incr addrStep (
        .baseAddr  (lastAddr_q),
        .nextAddr  (incAddr),
        .crossesKb (crossKb)
    );

    // ------------------------------------------------------------------------
    // core handshake
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrReady_q <= 1'b0;
        end else begin
            // free entry in both queues after this cycle's moves;
            // a sequential beat also asks for an address slot
            wrReady_q <= (aCountNext < `AWB_ADDR_DEPTH) &&
                         (dCountNext < `AWB_DATA_DEPTH);
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            unbufBusy_q <= 1'b0;
        end else begin
            if (unbufPush) begin
                unbufBusy_q <= 1'b1;
            end else if (wrDone_q) begin
                unbufBusy_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // drain report
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drainDone_q <= 1'b0;
        end else begin
            drainDone_q <= (accessReq | drainCmd | waitForInt) & allDone;
        end
    end

    // ------------------------------------------------------------------------
    // response of the closing data phase
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrDone_q  <= 1'b0;
            wrError_q <= 1'b0;
        end else begin
            wrDone_q <= 1'b0;
            // only unbuffered writes report errors
            if (advance && dphValid_q && dphUnbuf_q) begin
                wrDone_q  <= 1'b1;
                wrError_q <= (HRESP == `AWB_RESP_ERROR);
            end
        end
    end

    // ------------------------------------------------------------------------
    // data phase
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dphValid_q <= 1'b0;
            dphUnbuf_q <= 1'b0;
            hwdata_q   <= `AWB_RST_DATA;
        end else begin
            // address phase moves into data phase
            if (advance) begin
                dphValid_q <= prevActive;
                dphUnbuf_q <= apUnbuf_q & prevActive;
                hwdata_q   <= apData_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // address phase control
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            htrans_q  <= `AWB_TRANS_IDLE;
            hwrite_q  <= 1'b0;
            apUnbuf_q <= 1'b0;
            hburst_q  <= `AWB_BURST_INCR;
        end else begin
            if (advance) begin
                if (issue) begin
                    htrans_q  <= candSeq ? `AWB_TRANS_SEQ : `AWB_TRANS_NSEQ;
                    hwrite_q  <= 1'b1;
                    apUnbuf_q <= ~seqBeat & aHead[`AWB_AENT_UNBUF];
                end else begin
                    htrans_q  <= `AWB_TRANS_IDLE;
                    hwrite_q  <= 1'b0;
                    apUnbuf_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // address phase payload
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            haddr_q    <= `AWB_RST_ADDR;
            hsize_q    <= `AWB_SIZE_WORD;
            apData_q   <= `AWB_RST_DATA;
            lastAddr_q <= `AWB_RST_ADDR;
        end else begin
            // payload only moves with a new transfer
            if (advance && issue) begin
                haddr_q    <= candAddr;
                hsize_q    <= candSize;
                apData_q   <= dHead[31:0];
                lastAddr_q <= candAddr;
            end
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign wrReady   = wrReady_q;
    assign wrDone    = wrDone_q;
    assign wrError   = wrError_q;
    assign drainDone = drainDone_q;
    assign HADDR     = haddr_q;
    assign HTRANS    = htrans_q;
    assign HWRITE    = hwrite_q;
    assign HSIZE     = hsize_q;
    assign HBURST    = hburst_q;
    assign HWDATA    = hwdata_q;
endmodule // awb_write_buffer

`default_nettype wire

/* testbench/awb_slave_model.sv */
// behavioural bus slave: logs completed writes, stalls and errors on demand
// assumes busClkEn marks the bus clock edges of ref_clk
`default_nettype none
module awb_slave_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        busClkEn,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HADDR,
    input  wire logic [31:0] HWDATA,
    input  wire logic [3:0]  stallN,
    input  wire logic        errOn,
    output logic             HREADY,
    output logic [1:0]       HRESP
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [33:0] logA[$];
    logic [31:0] logD[$];
    logic        phV_q;
    logic [33:0] phA_q;
    logic [3:0]  cnt_q;
    assign HREADY = !(phV_q && cnt_q != 4'h0);
    assign HRESP = (errOn && phV_q) ? 2'h1 : 2'h0;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phV_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (busClkEn) begin
            if (!HREADY) begin
                cnt_q <= cnt_q - 4'h1;
            end else begin
                if (phV_q) begin
                    logA.push_back(phA_q);
                    logD.push_back(HWDATA);
                end
                phV_q <= HTRANS[1] && HWRITE;
                phA_q <= {HSIZE[1:0], HADDR};
                cnt_q <= stallN;
            end
        end
    end
endmodule // awb_slave_model
`default_nettype wire

/* testbench/awb_write_buffer_assertions.sv */
// bus-side checker of the write buffer
// assumes it is bound to every awb_write_buffer
`include "awb_consts.vh"
`default_nettype none
module awb_wb_assertions (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        wrValid,
    input wire logic [31:0] wrAddr,
    input wire logic [1:0]  wrSize,
    input wire logic [31:0] wrData,
    input wire logic        wrSeq,
    input wire logic        wrBufferable,
    input wire logic        wrBusSpace,
    input wire logic        wrTcmHit,
    input wire logic        wrReady,
    input wire logic        wrDone,
    input wire logic        wrError,
    input wire logic        bufEnable,
    input wire logic        accessReq,
    input wire logic        drainCmd,
    input wire logic        waitForInt,
    input wire logic        drainDone,
    input wire logic        busClkEn,
    input wire logic        HREADY,
    input wire logic [1:0]  HRESP,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [2:0]  HSIZE,
    input wire logic [2:0]  HBURST,
    input wire logic [31:0] HWDATA
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_hold_en; !busClkEn |=> $stable({HADDR, HTRANS, HSIZE, HWRITE}); endproperty
    a_hold_en: assert property (p_hold_en) else $error("bus moved off enable");
    property p_hold_wait; busClkEn && !HREADY |=> $stable({HADDR, HTRANS, HSIZE, HWDATA}); endproperty
    a_hold_wait: assert property (p_hold_wait) else $error("bus moved in wait");
    property p_seq_word; HTRANS == `AWB_TRANS_SEQ |-> HSIZE == `AWB_SIZE_WORD; endproperty
    a_seq_word: assert property (p_seq_word) else $error("seq size");
    property p_seq_incr; HTRANS == `AWB_TRANS_SEQ && $changed(HADDR) |-> HADDR == $past(HADDR) + 32'h4; endproperty
    a_seq_incr: assert property (p_seq_incr) else $error("seq address");
    property p_kb_split; HTRANS == `AWB_TRANS_SEQ |-> HADDR[9:0] != 10'h0; endproperty
    a_kb_split: assert property (p_kb_split) else $error("seq over 1KB");
    property p_nseq_gap; HTRANS == `AWB_TRANS_NSEQ && $changed(HADDR) |-> $past(HTRANS) == `AWB_TRANS_IDLE; endproperty
    a_nseq_gap: assert property (p_nseq_gap) else $error("no idle before nseq");
    property p_write; HTRANS != `AWB_TRANS_IDLE |-> HWRITE; endproperty
    a_write: assert property (p_write) else $error("not a write");
    property p_drained; drainDone |-> HTRANS == `AWB_TRANS_IDLE && $past(accessReq || drainCmd || waitForInt); endproperty
    a_drained: assert property (p_drained) else $error("drain early");
    property p_done_pulse; wrDone |=> !wrDone; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_reset; $fell(rst) |-> !wrReady && HTRANS == `AWB_TRANS_IDLE; endproperty
    a_reset: assert property (p_reset) else $error("reset state");
    c_seq: cover property (HTRANS == `AWB_TRANS_SEQ);
    c_wait: cover property (busClkEn && !HREADY);
    c_err: cover property (wrDone && wrError);
endmodule // awb_wb_assertions
bind awb_write_buffer awb_wb_assertions awb_wb_assertions_inst (.ref_clk, .rst, .wrValid, .wrAddr,
    .wrSize, .wrData, .wrSeq, .wrBufferable, .wrBusSpace, .wrTcmHit, .wrReady, .wrDone, .wrError,
    .bufEnable, .accessReq, .drainCmd, .waitForInt, .drainDone, .busClkEn, .HREADY, .HRESP, .HADDR,
    .HTRANS, .HWRITE, .HSIZE, .HBURST, .HWDATA);
`default_nettype wire

/* testbench/tb_awb_write_buffer.sv */
// self-checking bench of the write buffer with a behavioural slave
// assumes a 2:1 core to bus clock ratio
`include "awb_consts.vh"
`default_nettype none
module tb_awb_write_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, busClkEn = 1'b0, errOn = 1'b0, sawStall = 1'b0;
    logic wrValid = 1'b0, wrSeq = 1'b0, wrBufferable = 1'b1, wrBusSpace = 1'b1, wrTcmHit = 1'b0;
    logic bufEnable = 1'b1, accessReq = 1'b0, drainCmd = 1'b0, waitForInt = 1'b0;
    logic [31:0] wrAddr = 32'h0, wrData = 32'h0;
    logic [1:0] wrSize = 2'h0;
    logic [3:0] stallN = 4'h0;
    wire logic wrReady, wrDone, wrError, drainDone, HREADY, HWRITE;
    wire logic [1:0] HRESP, HTRANS;
    wire logic [2:0] HSIZE, HBURST;
    wire logic [31:0] HADDR, HWDATA;
    int bad_count = 0, n_compared = 0, nDone = 0;
    awb_write_buffer awb_write_buffer_inst (.ref_clk, .rst, .wrValid, .wrAddr, .wrSize, .wrData,
        .wrSeq, .wrBufferable, .wrBusSpace, .wrTcmHit, .wrReady, .wrDone, .wrError, .bufEnable,
        .accessReq, .drainCmd, .waitForInt, .drainDone, .busClkEn, .HREADY, .HRESP, .HADDR,
        .HTRANS, .HWRITE, .HSIZE, .HBURST, .HWDATA);
    awb_slave_model awb_slave_model_inst (.ref_clk, .rst, .busClkEn, .HTRANS, .HWRITE, .HSIZE,
        .HADDR, .HWDATA, .stallN, .errOn, .HREADY, .HRESP);
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) busClkEn <= #1 ~busClkEn;
    always @(posedge ref_clk) if (wrDone === 1'b1) nDone++;
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic clr();
        awb_slave_model_inst.logA.delete();
        awb_slave_model_inst.logD.delete();
    endtask
    task automatic ent(input int i, input logic [33:0] a, input logic [31:0] d);
        chk("entry", a, awb_slave_model_inst.logA[i]);
        chk("data", 34'(d), 34'(awb_slave_model_inst.logD[i]));
    endtask
    // core holds the write until taken, leaves wrValid up
    task automatic store(input logic [31:0] a, d, input logic [1:0] s, input logic q);
        int n;
        n = 0;
        {wrValid, wrAddr, wrData, wrSize, wrSeq, wrBufferable} = {1'b1, a, d, s, q, 1'b1};
        while (wrReady !== 1'b1 && n < 300) begin
            sawStall = 1'b1;
            tick();
            n++;
        end
        chk("wrReady", 34'h1, 34'(wrReady));
        tick();
    endtask
    task automatic unbuf(input logic [31:0] a, input logic b, err);
        int n;
        n = 0;
        {wrValid, wrAddr, wrData, wrSize, wrSeq, wrBufferable} = {1'b1, a, ~a, 2'h2, 1'b0, b};
        while (wrDone !== 1'b1 && n < 2000) begin
            tick();
            n++;
        end
        chk("wrDone", 34'h1, 34'(wrDone));
        chk("wrError", 34'(err), 34'(wrError));
        wrValid = 1'b0;
        tick();
    endtask
    task automatic drain(input int w, input int nExp);
        int n;
        n = 0;
        {accessReq, waitForInt, drainCmd} = 3'(1 << w);
        while (drainDone !== 1'b1 && n < 2000) begin
            tick();
            n++;
        end
        chk("drainDone", 34'h1, 34'(drainDone));
        chk("writes", 34'(nExp), 34'(awb_slave_model_inst.logA.size()));
        {accessReq, waitForInt, drainCmd} = 3'h0;
        tick();
    endtask
    task automatic t_singles();
        clr();
        {stallN, sawStall} = {4'h8, 1'b0};
        for (int i = 0; i < 8; i++) store(32'h100 + 32'(4 * i), 32'ha0 + 32'(i), 2'(i % 3), 1'b0);
        wrValid = 1'b0;
        chk("stall", 34'h1, 34'(sawStall));
        drain(0, 8);
        for (int i = 0; i < 8; i++) ent(i, {2'(i % 3), 32'h100 + 32'(4 * i)}, 32'ha0 + 32'(i));
        $display("test singles done");
    endtask
    task automatic t_multi();
        clr();
        stallN = 4'h3;
        store(32'h3f0, 32'hb0, 2'h2, 1'b0);
        for (int i = 1; i < 8; i++) store(32'h0, 32'hb0 + 32'(i), 2'h2, 1'b1);
        wrValid = 1'b0;
        bufEnable = 1'b0;
        drain(1, 8);
        bufEnable = 1'b1;
        for (int i = 0; i < 8; i++) ent(i, {2'h2, 32'h3f0 + 32'(4 * i)}, 32'hb0 + 32'(i));
        $display("test multiple done");
    endtask
    task automatic t_err();
        clr();
        {errOn, stallN, nDone} = {1'b1, 4'h1, 0};
        store(32'h200, 32'hc0, 2'h2, 1'b0);
        unbuf(32'h204, 1'b0, 1'b1);
        chk("doneCount", 34'h1, 34'(nDone));
        {errOn, bufEnable} = 2'b00;
        tick();
        unbuf(32'h208, 1'b1, 1'b0);
        bufEnable = 1'b1;
        wrTcmHit = 1'b1;
        unbuf(32'h20c, 1'b1, 1'b0);
        {wrTcmHit, wrBusSpace} = 2'b00;
        unbuf(32'h210, 1'b1, 1'b0);
        wrBusSpace = 1'b1;
        drain(2, 5);
        ent(1, {2'h2, 32'h204}, ~32'h204);
        ent(4, {2'h2, 32'h210}, ~32'h210);
        $display("test errors done");
    endtask
    task automatic t_reset();
        stallN = 4'h8;
        store(32'h300, 32'hd0, 2'h2, 1'b0);
        wrValid = 1'b0;
        rst = 1'b1;
        tick();
        chk("HTRANS", 34'h0, 34'(HTRANS));
        chk("HWRITE", 34'h0, 34'(HWRITE));
        chk("HBURST", 34'(`AWB_BURST_INCR), 34'(HBURST));
        chk("wrReady", 34'h0, 34'(wrReady));
        {rst, stallN} = {1'b0, 4'h0};
        clr();
        drain(0, 0);
        $display("test reset done");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'b0;
        tick();
        t_singles();
        t_multi();
        t_err();
        t_reset();
        tally_and_finish();
    end
    initial begin
        #3000000;
        bad_count++;
        tally_and_finish();
    end
endmodule // tb_awb_write_buffer
`default_nettype wire
